// >>> verilog/cos_pkg.sv
// Constants and carrier types for the isolated input port with change-of-state interrupt.
// Assumes an Avalon-MM master whose byte address carries the host I/O address in its low ten bits.
package cos_pkg;

    // Bus widths.
    localparam int AV_ADDR_W = 11;
    localparam int DATA_W    = 8;
    localparam int GROUPS    = 3;
    localparam int GROUP_W   = 16;
    localparam int INPUTS    = 48;

    // Address split: bit 10 picks the local extension block, bits 9..3 hold the card base.
    localparam int EXT_BIT   = 10;
    localparam int BASE_HI   = 9;
    localparam int BASE_LO   = 3;

    // Byte offsets inside the eight-byte input block.
    localparam logic [2:0] OFF_P0_LO  = 3'h0;
    localparam logic [2:0] OFF_P0_HI  = 3'h1;
    localparam logic [2:0] OFF_P1_LO  = 3'h2;
    localparam logic [2:0] OFF_UNUSED3 = 3'h3;
    localparam logic [2:0] OFF_P1_HI  = 3'h4;
    localparam logic [2:0] OFF_P2_LO  = 3'h5;
    localparam logic [2:0] OFF_RESUME = 3'h5;
    localparam logic [2:0] OFF_P2_HI  = 3'h6;
    localparam logic [2:0] OFF_UNUSED7 = 3'h7;

    // Offsets inside the extension block (address bit 10 set, bits 9..3 zero).
    localparam logic [2:0] EXT_STATUS = 3'h0;
    localparam logic [2:0] EXT_MASK   = 3'h1;
    localparam logic [2:0] EXT_CTRL   = 3'h2;

    // Reset values.
    localparam logic [GROUPS-1:0] STATUS_RST = 3'h0;
    localparam logic [GROUPS-1:0] MASK_RST   = 3'h7;
    localparam logic              DETECT_RST = 1'b1;
    localparam logic [DATA_W-1:0] UNMAPPED_DATA = 8'h00;

    // Host interrupt lines that the jumper may select: 2..7, 10..12, 14..15.
    localparam logic [15:0] IRQ_LEGAL = 16'hDCFC;

    // One bus request from the Avalon master.
    typedef struct packed {
        logic                 read;
        logic                 write;
        logic [AV_ADDR_W-1:0] address;
        logic [DATA_W-1:0]    writedata;
    } av_req_t;

endpackage

// >>> verilog/isolated_input_port_cos_irq.sv
// Isolated 48-input port with latched change-of-state interrupt, reached over Avalon-MM.
// Assumes field inputs and switch straps are steady levels; the bus master follows Avalon waitrequest rules.
//
// What this block does
// RL1 - Inputs are sampled in three 16-bit groups, and unfitted groups of smaller builds read as zero.
// RL2 - A change on any enabled input latches an interrupt request that stays high until cleared.
// RL3 - Without the interrupt option fitted no interrupt request is ever raised.
// RL4 - Mode switch 0 enables change detection on channels 0-15, switch 1 on 16-31, switch 2 on 32-47.
// RL5 - A mode switch ON includes its group in interrupt generation and OFF excludes it.
// RL6 - The remaining two mode switches have no effect.
// RL7 - The request goes out on exactly one host interrupt line chosen by jumper among 2-7, 10-12 and 14-15.
// RL8 - The card answers a contiguous block of eight byte addresses starting at its base.
// RL9 - The host places the base within 100-3F0 hex, clear of 1F0-1F8 and of any other function.
// RL10 - Address lines 9 down to 3 are compared with seven base switches and a full match selects the card.
// RL11 - A base switch ON matches a 0 on its address line and OFF matches a 1.
// RL12 - Address lines 2 to 0 choose the byte within the block.
// RL13 - Offsets 0,1 give port 0 low/high, 2 and 4 give port 1 low/high, 5 and 6 port 2, and 3 and 7 are unused.
// RL14 - Any read of the block clears the pending interrupt and suspends change detection.
// RL15 - A write to offset 5 resumes change detection, which the host issues after reading inputs.
// RL16 - The data bus is driven only in a decoded read, and writes to any other offset are ignored.
// RL17 - Inputs are synchronised and each enabled input is compared with its previous sample every cycle.

`timescale 1ns/10ps

module isolated_input_port_cos_irq (
    input  wire logic                            core_clk,
    input  wire logic                            resetn,
    input  wire cos_pkg::av_req_t                av_req,
    output logic     [cos_pkg::DATA_W-1:0]       av_readdata,
    output logic                                 av_waitrequest,
    output logic                                 data_drive,
    output logic                                 irq,
    input  wire logic [6:0]                      base_match_switches,
    input  wire logic [4:0]                      mode_switches,
    input  wire logic [cos_pkg::GROUPS-1:0]      group_fitted,
    input  wire logic                            cos_option_fitted,
    input  wire logic [3:0]                      irq_jumper,
    input  wire logic [cos_pkg::INPUTS-1:0]      field_inputs,
    output logic     [15:0]                      host_irq
);
    import cos_pkg::*;

    // All state of the block in one record.
    typedef struct packed {
        logic                 ack;
        logic [DATA_W-1:0]    rdata;
        logic [INPUTS-1:0]    sync1;
        logic [INPUTS-1:0]    sync2;
        logic [INPUTS-1:0]    prev;
        logic                 primed;
        logic                 detect_en;
        logic [GROUPS-1:0]    cos_status;
        logic [GROUPS-1:0]    mask;
        logic                 irq_req;
    } state_t;

    localparam state_t STATE_RST = '{
        ack:        1'b0,
        rdata:      UNMAPPED_DATA,
        sync1:      '0,
        sync2:      '0,
        prev:       '0,
        primed:     1'b0,
        detect_en:  DETECT_RST,
        cos_status: STATUS_RST,
        mask:       MASK_RST,
        irq_req:    1'b0
    };

    state_t state_reg;
    state_t state_next;

    // Negative-true base compare: a switch ON (1) must see a 0 on its line.
    function automatic logic base_hit(input logic [BASE_HI-BASE_LO:0] lines,
                                      input logic [BASE_HI-BASE_LO:0] switches);
        base_hit = (lines == ~switches); // RL10 RL11
    endfunction

    // Byte of a fitted group taken from the synchronised inputs; unfitted groups read zero.
    function automatic logic [DATA_W-1:0] group_byte(input logic [INPUTS-1:0]  bits,
                                                     input logic [GROUPS-1:0]  fitted,
                                                     input int unsigned        grp,
                                                     input logic               high);
        logic [GROUP_W-1:0] word;
        word = '0;
        if (fitted[grp]) begin
            word = bits[grp*GROUP_W +: GROUP_W]; // RL1
        end
        group_byte = high ? word[GROUP_W-1:DATA_W] : word[DATA_W-1:0];
    endfunction

    logic              req_any;
    logic              take;
    logic              accept;
    logic              io_hit;
    logic              ext_hit;
    logic [2:0]        offset;
    logic [DATA_W-1:0] read_value;
    logic [GROUPS-1:0] group_active;
    logic [GROUPS-1:0] group_change;
    logic [GROUPS-1:0] status_clear;

    // Bus decode: a request is taken in its first cycle and answered one cycle later.
    always_comb begin
        req_any = av_req.read | av_req.write;
        take    = req_any & ~state_reg.ack;
        accept  = req_any & state_reg.ack;
        offset  = av_req.address[BASE_LO-1:0]; // RL12
        io_hit  = ~av_req.address[EXT_BIT]
                  & base_hit(av_req.address[BASE_HI:BASE_LO], base_match_switches); // RL8 RL10
        ext_hit = av_req.address[EXT_BIT] & (av_req.address[BASE_HI:BASE_LO] == 7'h00);
    end

    // Read value for the addressed byte; unused and unmapped offsets read zero.
    always_comb begin
        read_value = UNMAPPED_DATA;
        if (io_hit) begin
            unique case (offset)
                OFF_P0_LO:   read_value = group_byte(state_reg.sync2, group_fitted, 0, 1'b0); // RL13
                OFF_P0_HI:   read_value = group_byte(state_reg.sync2, group_fitted, 0, 1'b1); // RL13
                OFF_P1_LO:   read_value = group_byte(state_reg.sync2, group_fitted, 1, 1'b0); // RL13
                OFF_P1_HI:   read_value = group_byte(state_reg.sync2, group_fitted, 1, 1'b1); // RL13
                OFF_P2_LO:   read_value = group_byte(state_reg.sync2, group_fitted, 2, 1'b0); // RL13
                OFF_P2_HI:   read_value = group_byte(state_reg.sync2, group_fitted, 2, 1'b1); // RL13
                OFF_UNUSED3: read_value = UNMAPPED_DATA; // RL13
                OFF_UNUSED7: read_value = UNMAPPED_DATA; // RL13
            endcase
        end else if (ext_hit) begin
            if (offset == EXT_STATUS) begin
                read_value = {5'h00, state_reg.cos_status};
            end else if (offset == EXT_MASK) begin
                read_value = {5'h00, state_reg.mask};
            end else if (offset == EXT_CTRL) begin
                read_value = {7'h00, state_reg.detect_en};
            end
        end
    end

    // Change detection per group, gated by option, mode switch, fitting and the suspend flag.
    always_comb begin
        for (int g = 0; g < GROUPS; g++) begin
            group_active[g] = cos_option_fitted // RL3
                              & mode_switches[g] // RL4 RL5
                              & group_fitted[g]
                              & state_reg.detect_en
                              & state_reg.primed;
            group_change[g] = group_active[g]
                              & (|(state_reg.sync2[g*GROUP_W +: GROUP_W]
                                   ^ state_reg.prev[g*GROUP_W +: GROUP_W])); // RL17
        end
    end

    // Status clear: any read of the input block, or a read of the status register.
    always_comb begin
        status_clear = '0;
        if (accept & av_req.read & io_hit) begin
            status_clear = '1; // RL14
        end else if (accept & av_req.read & ext_hit & (offset == EXT_STATUS)) begin
            status_clear = '1;
        end
    end

    // Next state; mode switches 3 and 4 are never looked at.
    always_comb begin
        state_next = state_reg; // RL6
        state_next.ack = take;
        if (take) begin
            state_next.rdata = read_value;
        end

        // Two-stage synchroniser, then the previous-sample register.
        state_next.sync1  = field_inputs; // RL17
        state_next.sync2  = state_reg.sync1;
        state_next.prev   = state_reg.sync2;
        state_next.primed = 1'b1;

        // Set wins over clear so a change in the clearing cycle is not lost.
        state_next.cos_status = (state_reg.cos_status & ~status_clear) | group_change; // RL2

        // Suspend on any block read, resume on a write to the resume offset.
        if (accept & av_req.read & io_hit) begin
            state_next.detect_en = 1'b0; // RL14
        end else if (accept & av_req.write & io_hit & (offset == OFF_RESUME)) begin
            state_next.detect_en = 1'b1; // RL15
        end

        // Only the mask register takes write data; apart from the resume write above, all other writes are dropped.
        if (accept & av_req.write & ext_hit & (offset == EXT_MASK)) begin
            state_next.mask = av_req.writedata[GROUPS-1:0]; // RL16
        end

        // Latched request follows unmasked status.
        state_next.irq_req = cos_option_fitted
                             & (|(state_next.cos_status & state_next.mask)); // RL2 RL3
    end

    // State register.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= STATE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // Bus answer and interrupt outputs.
    always_comb begin
        av_waitrequest = req_any & ~state_reg.ack;
        av_readdata    = state_reg.rdata;
        data_drive     = state_reg.ack & av_req.read & io_hit; // RL16
        irq            = state_reg.irq_req;
        host_irq       = '0;
        if (state_reg.irq_req & IRQ_LEGAL[irq_jumper]) begin
            host_irq[irq_jumper] = 1'b1; // RL7
        end
    end

endmodule // isolated_input_port_cos_irq

// >>> bench/cos_port_monitor.sv
// Checker for the bus decode and interrupt outputs of the isolated input port.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module cos_port_monitor
    import cos_pkg::*;
(
    input wire logic                 core_clk,
    input wire logic                 resetn,
    input wire av_req_t              av_req,
    input wire logic [DATA_W-1:0]    av_readdata,
    input wire logic                 av_waitrequest,
    input wire logic                 data_drive,
    input wire logic                 irq,
    input wire logic [6:0]           base_match_switches,
    input wire logic [4:0]           mode_switches,
    input wire logic [GROUPS-1:0]    group_fitted,
    input wire logic                 cos_option_fitted,
    input wire logic [3:0]           irq_jumper,
    input wire logic [15:0]          host_irq
);
    logic done;
    logic hit;
    // Answer cycle of a read, and a full match of the card base.
    assign done = av_req.read && !av_waitrequest;
    assign hit  = !av_req.address[EXT_BIT] && (av_req.address[BASE_HI:BASE_LO] == ~base_match_switches);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_blk_read;
        done && hit;
    endsequence
    a_decode_match: assert property (done |-> data_drive == hit) else $error("decode mismatch");
    a_drive_in_read: assert property (data_drive |-> done && hit) else $error("bus driven");
    a_unused_zero: assert property (done && hit && av_req.address[1:0] == 2'h3
        |-> av_readdata == UNMAPPED_DATA) else $error("unused offset data");
    a_unfitted_zero: assert property (done && hit && av_req.address[2:1] == 2'h0 && !group_fitted[0]
        |-> av_readdata == 8'h00) else $error("unfitted group data");
    a_no_option: assert property (!cos_option_fitted [*2] |-> !irq) else $error("irq without option");
    a_irq_line: assert property (host_irq == ((irq && IRQ_LEGAL[irq_jumper]) ? 16'h1 << irq_jumper : 16'h0))
        else $error("host line wrong");
    a_read_suspends: assert property (s_blk_read |=> ##1 (!$rose(irq)) [*2]) else $error("irq after read");
    a_mode_off: assert property (!irq && mode_switches[2:0] == 3'h0 && !av_req.write |=> !irq)
        else $error("irq with groups off");
endmodule // cos_port_monitor

// >>> bench/host_bus_model.sv
// Host processor model: byte transfers over Avalon-MM with waitrequest.
// Assumes waitrequest is sampled at rising edges of core_clk.
`timescale 1ns/10ps
module host_bus_model
    import cos_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 av_waitrequest,
    input  wire logic [DATA_W-1:0]    av_readdata,
    output av_req_t                   av_req
);
    // Bus stays idle until the first request.
    initial av_req = '0;
    // Raises a request after an edge, holds it until waitrequest is seen low, then releases it.
    task automatic xfer(input logic wr, input logic [AV_ADDR_W-1:0] a, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge core_clk);
        av_req <= '{read: !wr, write: wr, address: a, writedata: wd};
        do @(posedge core_clk); while (av_waitrequest !== 1'h0);
        rd = av_readdata;
        av_req <= '0;
    endtask
endmodule // host_bus_model

// >>> bench/tb_isolated_input_port_cos_irq.sv
// Self-checking bench for the isolated input port with change-of-state interrupt.
// Assumes the host model makes bus transfers and the checker is bound below.
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_isolated_input_port_cos_irq;
    import cos_pkg::*;
    localparam logic [10:0] BASE = 11'h2D8;
    localparam logic [7:0] EXP [8] = '{8'hC0, 8'hC1, 8'hB2, 8'h00, 8'hB3, 8'hA4, 8'hA5, 8'h00};
    logic core_clk, resetn, drv, irq, wreq, opt;
    logic [7:0] rdat, d;
    logic [4:0] mode;
    logic [3:0] jmp;
    logic [2:0] fit;
    logic [47:0] fin, v;
    logic [15:0] hirq;
    av_req_t req;
    int err_count, total_checks;
    host_bus_model host (.core_clk(core_clk), .av_waitrequest(wreq), .av_readdata(rdat), .av_req(req));
    isolated_input_port_cos_irq uut (.core_clk(core_clk), .resetn(resetn), .av_req(req), .av_readdata(rdat),
        .av_waitrequest(wreq), .data_drive(drv), .irq(irq), .base_match_switches(~BASE[9:3]),
        .mode_switches(mode), .group_fitted(fit), .cos_option_fitted(opt), .irq_jumper(jmp),
        .field_inputs(fin), .host_irq(hirq));
    // Read and write one byte of the card block, and change inputs then judge the interrupt.
    task automatic rd(input logic [2:0] o, input logic [7:0] e);
        host.xfer(1'h0, {BASE[10:3], o}, 8'h00, d);
        `CHK(d, e)
    endtask
    task automatic wr(input logic [2:0] o);
        host.xfer(1'h1, {BASE[10:3], o}, 8'h00, d);
    endtask
    task automatic chg(input logic [47:0] nv, input logic e);
        @(posedge core_clk) fin <= nv;
        repeat (6) @(posedge core_clk);
        `CHK(irq, e)
    endtask
    // Latch, host line per jumper, clear and suspend by read, resume by write.
    task automatic t_cos();
        chg(48'h1, 1'h1);
        for (int j = 0; j < 16; j++) begin
            @(posedge core_clk) jmp <= j[3:0];
            repeat (2) @(posedge core_clk);
            `CHK(hirq, IRQ_LEGAL[j] ? 16'h1 << j : 16'h0)
        end
        rd(3'h0, 8'h01);
        repeat (2) @(posedge core_clk);
        `CHK(irq, 1'h0)
        chg(48'h3, 1'h0);
        wr(3'h0);
        chg(48'h7, 1'h0);
        wr(OFF_RESUME);
        chg(48'h6, 1'h1);
        rd(3'h7, 8'h00);
        wr(OFF_RESUME);
    endtask
    // Each group enabled alone; reserved switches stay on throughout.
    task automatic t_mode();
        v = 48'h6;
        @(posedge core_clk) mode <= 5'h18;
        v = v ^ 48'h1;
        chg(v, 1'h0);
        for (int g = 0; g < 3; g++) begin
            @(posedge core_clk) mode <= 5'h18 | (5'h1 << g);
            v = v ^ (48'h1 << (16 * ((g + 1) % 3)));
            chg(v, 1'h0);
            v = v ^ (48'h1 << (16 * g));
            chg(v, 1'h1);
            rd(3'h3, 8'h00);
            wr(OFF_RESUME);
        end
        @(posedge core_clk) opt <= 1'h0;
        chg(~v, 1'h0);
        rd(3'h7, 8'h00);
        wr(OFF_RESUME);
        @(posedge core_clk) opt <= 1'h1;
    endtask
    // Extension registers: a masked change latches status only, a status read clears it.
    task automatic t_ext();
        host.xfer(1'h1, 11'h401, 8'h00, d);
        v = ~v ^ (48'h1 << 32);
        chg(v, 1'h0);
        host.xfer(1'h0, 11'h402, 8'h00, d);
        `CHK(d, 8'h01)
        host.xfer(1'h0, 11'h400, 8'h00, d);
        `CHK(d, 8'h04)
        host.xfer(1'h0, 11'h400, 8'h00, d);
        `CHK(d, 8'h00)
        host.xfer(1'h1, 11'h401, 8'h07, d);
        host.xfer(1'h0, 11'h401, 8'h00, d);
        `CHK(d, 8'h07)
    endtask
    // Byte map of the block, an unfitted group and a foreign base.
    task automatic t_reads();
        @(posedge core_clk) fin <= 48'hA5A4_B3B2_C1C0;
        repeat (4) @(posedge core_clk);
        for (int o = 0; o < 8; o++) rd(o[2:0], EXP[o]);
        @(posedge core_clk) fit <= 3'h6;
        repeat (4) @(posedge core_clk);
        rd(3'h1, 8'h00);
        host.xfer(1'h0, BASE ^ 11'h008, 8'h00, d);
        `CHK(d, UNMAPPED_DATA)
    endtask
    // Prints the verdict and ends the run.
    task automatic close_out();
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Clock of 4 ns period.
    initial begin
        core_clk = 1'h0;
        forever #2 core_clk = ~core_clk;
    end
    // Reset for 8 cycles, then the scenarios.
    initial begin
        {resetn, fin, mode, fit, opt, jmp} = {1'h0, 48'h0, 5'h07, 3'h7, 1'h1, 4'h5};
        repeat (8) @(posedge core_clk);
        resetn <= 1'h1;
        repeat (4) @(posedge core_clk);
        t_cos();
        t_mode();
        t_ext();
        t_reads();
        close_out();
    end
    // Cuts a hang short.
    initial begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        close_out();
    end
endmodule // tb_isolated_input_port_cos_irq
bind isolated_input_port_cos_irq cos_port_monitor mon (.core_clk(core_clk), .resetn(resetn), .av_req(av_req),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .data_drive(data_drive), .irq(irq),
    .base_match_switches(base_match_switches), .mode_switches(mode_switches), .group_fitted(group_fitted),
    .cos_option_fitted(cos_option_fitted), .irq_jumper(irq_jumper), .host_irq(host_irq));
